/* src/icx_cfg.svh */
// Constants of the two-level interrupt controller.
// Assumes a single clock domain and an 8-bit special-register port.
`ifndef ICX_CFG_SVH
`define ICX_CFG_SVH

`define ICX_NSRC 21
`define ICX_SRC_W 5
`define ICX_T2_SRC 5
`define ICX_RSVD_SRC 17
`define ICX_VEC_BASE 16'h0003
`define ICX_VEC_SHIFT 3
`define ICX_RESET_VEC 16'h0000
`define ICX_CALL_CYC 3'h5
`define ICX_CNT_ONE 3'h1
`define ICX_GLB_BIT 7
`define ICX_ADDR_IE 8'hA8
`define ICX_ADDR_IP 8'hB8
`define ICX_ADDR_EIE1 8'hE6
`define ICX_ADDR_EXTENDED_PRIORITY_REG_A 8'hF6
`define ICX_ADDR_EIE2 8'hE7
`define ICX_ADDR_EXTENDED_PRIORITY_REG_B 8'hF7
`define ICX_REG_RST 8'h00
`define ICX_IP_RD_ONE 8'h80
`define ICX_IP_MASK 8'h7F
`define ICX_EIE2_MASK 8'h3B

`endif

/* src/icx_pkg.sv */
// Types and helpers of the two-level interrupt controller.
// Assumes icx_cfg.svh is on the include path.
`include "icx_cfg.svh"

package icx_pkg;

    typedef enum logic [1:0] {
        ICX_IDLE = 2'b00,
        ICX_CALL = 2'b01
    } icx_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_idx;
    } icx_sfr_req_t;

    typedef struct packed {
        logic [15:0] vector;
        logic [`ICX_SRC_W-1:0] src;
        logic level;
    } icx_call_t;

    // Lowest set index of a source vector
    function automatic logic [`ICX_SRC_W-1:0] icx_first(input logic [`ICX_NSRC-1:0] v);
        logic [`ICX_SRC_W-1:0] r;
        r = '0;
        for (int i = `ICX_NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[`ICX_SRC_W-1:0];
            end
        end
        return r;
    endfunction : icx_first

    function automatic logic [15:0] icx_vector(input logic [`ICX_SRC_W-1:0] s);
        return `ICX_VEC_BASE + ({11'h000, s} << `ICX_VEC_SHIFT);
    endfunction : icx_vector

endpackage : icx_pkg

/* src/icx_sfr.sv */
// Enable and priority registers of the interrupt controller.
// Assumes one access per cycle on the special-register port.
`timescale 1ns/1ns
module icx_sfr
    import icx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input icx_sfr_req_t req,
    output logic [7:0] rdata,
    // Decoded controls
    output logic glb_en,
    output logic [`ICX_NSRC-1:0] src_en,
    output logic [`ICX_NSRC-1:0] src_hi
);
    logic [7:0] ie_ff, ip_ff, eie1_ff, extended_priority_reg_a_ff, eie2_ff, extended_priority_reg_b_ff, rdata_ff;
    logic [7:0] nxt_ie, nxt_ip, nxt_eie1, nxt_extended_priority_reg_a, nxt_eie2, nxt_extended_priority_reg_b, nxt_rdata;

    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] adr,
                                       input icx_sfr_req_t r, input logic bitok);
        logic [7:0] m;
        m = 8'h01 << r.bit_idx;
        if (r.addr != adr) return cur;
        if (r.wr) return r.wdata;
        if (bitok && r.bit_set) return cur | m;
        if (bitok && r.bit_clr) return cur & ~m;
        return cur;
    endfunction : upd

    // ****************************************
    // Register update and read
    // ****************************************
    always_comb begin
        nxt_ie = upd(ie_ff, `ICX_ADDR_IE, req, 1'b1);
        nxt_ip = upd(ip_ff, `ICX_ADDR_IP, req, 1'b1) & `ICX_IP_MASK;
        nxt_eie1 = upd(eie1_ff, `ICX_ADDR_EIE1, req, 1'b0);
        nxt_extended_priority_reg_a = upd(extended_priority_reg_a_ff, `ICX_ADDR_EXTENDED_PRIORITY_REG_A, req, 1'b0);
        nxt_eie2 = upd(eie2_ff, `ICX_ADDR_EIE2, req, 1'b0) & `ICX_EIE2_MASK;
        nxt_extended_priority_reg_b = upd(extended_priority_reg_b_ff, `ICX_ADDR_EXTENDED_PRIORITY_REG_B, req, 1'b0) & `ICX_EIE2_MASK;
        nxt_rdata = rdata_ff;
        if (req.rd) begin
            case (req.addr)
                `ICX_ADDR_IE: nxt_rdata = ie_ff;
                `ICX_ADDR_IP: nxt_rdata = ip_ff | `ICX_IP_RD_ONE;
                `ICX_ADDR_EIE1: nxt_rdata = eie1_ff;
                `ICX_ADDR_EXTENDED_PRIORITY_REG_A: nxt_rdata = extended_priority_reg_a_ff;
                `ICX_ADDR_EIE2: nxt_rdata = eie2_ff;
                `ICX_ADDR_EXTENDED_PRIORITY_REG_B: nxt_rdata = extended_priority_reg_b_ff;
                default: nxt_rdata = `ICX_REG_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ie_ff <= `ICX_REG_RST;
            ip_ff <= `ICX_REG_RST;
            eie1_ff <= `ICX_REG_RST;
            extended_priority_reg_a_ff <= `ICX_REG_RST;
            eie2_ff <= `ICX_REG_RST;
            extended_priority_reg_b_ff <= `ICX_REG_RST;
            rdata_ff <= `ICX_REG_RST;
        end else begin
            ie_ff <= nxt_ie;
            ip_ff <= nxt_ip;
            eie1_ff <= nxt_eie1;
            extended_priority_reg_a_ff <= nxt_extended_priority_reg_a;
            eie2_ff <= nxt_eie2;
            extended_priority_reg_b_ff <= nxt_extended_priority_reg_b;
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata = rdata_ff;
    assign glb_en = ie_ff[`ICX_GLB_BIT];
    assign src_en = {eie2_ff[5:0], eie1_ff, ie_ff[6:0]};
    assign src_hi = {extended_priority_reg_b_ff[5:0], extended_priority_reg_a_ff, ip_ff[6:0]};

endmodule : icx_sfr

/* src/icx_arb.sv */
// Two-level priority resolver of the interrupt controller.
// Assumes pending flags and enables are stable within a cycle.
`timescale 1ns/1ns
module icx_arb
    import icx_pkg::*;
#(
    parameter int NSRC = `ICX_NSRC
) (
    // Sources
    input wire logic [NSRC-1:0] pend,
    input wire logic [NSRC-1:0] src_en,
    input wire logic [NSRC-1:0] src_hi,
    input wire logic glb_en,
    input wire logic [1:0] in_srv,
    // Result
    output logic [NSRC-1:0] act,
    output logic valid,
    output logic [`ICX_SRC_W-1:0] idx,
    output logic level
);
    if (NSRC != `ICX_NSRC) begin : g_bad_nsrc
        $error("icx_arb: NSRC must match the source table");
    end

    logic [NSRC-1:0] hi_act, lo_act;

    // ****************************************
    // Level then fixed order
    // ****************************************
    always_comb begin
        act = pend & src_en & {NSRC{glb_en}};
        hi_act = act & src_hi;
        lo_act = act & ~src_hi;
        valid = 1'b0;
        idx = '0;
        level = 1'b0;
        if (hi_act != '0 && !in_srv[1]) begin
            valid = 1'b1;
            idx = icx_first(hi_act);
            level = 1'b1;
        end else if (lo_act != '0 && in_srv == 2'b00) begin
            valid = 1'b1;
            idx = icx_first(lo_act);
        end
    end

endmodule : icx_arb

/* src/icx_top.sv */
// Two-level interrupt controller: registers, arbitration, call sequencing.
// Assumes the CPU marks instruction ends, returns and stalls synchronously.
`timescale 1ns/1ns
module icx_top
    import icx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input icx_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Source flags
    input wire logic [`ICX_NSRC-1:0] src_flag,
    input wire logic timer2_low_overflow_flag,
    input wire logic timer2_high_overflow_flag,
    // CPU side
    input wire logic cpu_instr_end,
    input wire logic return_from_interrupt,
    input wire logic cpu_stall,
    output logic long_call_start,
    output logic call_busy,
    output logic handler_enter,
    output icx_call_t call_info,
    output logic [1:0] level_in_service
);
    logic glb_en;
    logic [`ICX_NSRC-1:0] src_en, src_hi, pend, act;
    logic arb_valid, arb_level;
    logic [`ICX_SRC_W-1:0] arb_idx;

    icx_state_t state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic [1:0] srv_ff, nxt_srv;
    logic req_ff, nxt_req;
    icx_call_t req_info_ff, nxt_req_info;
    icx_call_t call_ff, nxt_call;

    // ****************************************
    // Registers and arbitration
    // ****************************************
    icx_sfr u_sfr (
        .clk(clk),
        .reset_n(reset_n),
        .req(sfr_req),
        .rdata(sfr_rdata),
        .glb_en(glb_en),
        .src_en(src_en),
        .src_hi(src_hi)
    );

    always_comb begin
        pend = src_flag;
        pend[`ICX_T2_SRC] = timer2_low_overflow_flag | timer2_high_overflow_flag;
        pend[`ICX_RSVD_SRC] = 1'b0;
    end

    icx_arb #(
        .NSRC(`ICX_NSRC)
    ) u_arb (
        .pend(pend),
        .src_en(src_en),
        .src_hi(src_hi),
        .glb_en(glb_en),
        .in_srv(nxt_srv),
        .act(act),
        .valid(arb_valid),
        .idx(arb_idx),
        .level(arb_level)
    );

    // ****************************************
    // Detection stage
    // ****************************************
    always_comb begin
        nxt_req = arb_valid;
        nxt_req_info.vector = icx_vector(arb_idx);
        nxt_req_info.src = arb_idx;
        nxt_req_info.level = arb_level;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_ff <= 1'b0;
            req_info_ff <= '0;
        end else begin
            req_ff <= nxt_req;
            req_info_ff <= nxt_req_info;
        end
    end

    // ****************************************
    // Call sequencing
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_call = call_ff;
        long_call_start = 1'b0;
        handler_enter = 1'b0;
        case (state_ff)
            ICX_IDLE: begin
                // A return itself is never the boundary; the next instruction is
                if (req_ff && cpu_instr_end && !return_from_interrupt && !cpu_stall) begin
                    long_call_start = 1'b1;
                    nxt_state = ICX_CALL;
                    nxt_cnt = `ICX_CALL_CYC - `ICX_CNT_ONE;
                    nxt_call = req_info_ff;
                end
            end
            ICX_CALL: begin
                if (!cpu_stall) begin
                    if (cnt_ff == `ICX_CNT_ONE) begin
                        handler_enter = 1'b1;
                        nxt_state = ICX_IDLE;
                    end
                    nxt_cnt = cnt_ff - `ICX_CNT_ONE;
                end
            end
            default: begin
                nxt_state = ICX_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ICX_IDLE;
            cnt_ff <= '0;
            call_ff <= '{vector: `ICX_RESET_VEC, src: '0, level: 1'b0};
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            call_ff <= nxt_call;
        end
    end

    // ****************************************
    // Levels in service
    // ****************************************
    always_comb begin
        nxt_srv = srv_ff;
        if (return_from_interrupt) begin
            if (srv_ff[1]) begin
                nxt_srv[1] = 1'b0;
            end else begin
                nxt_srv[0] = 1'b0;
            end
        end
        if (handler_enter) begin
            nxt_srv[call_ff.level] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srv_ff <= 2'b00;
        end else begin
            srv_ff <= nxt_srv;
        end
    end

    assign call_busy = (state_ff == ICX_CALL);
    assign call_info = call_ff;
    assign level_in_service = srv_ff;

    // ****************************************
    // Checks
    // ****************************************
    logic [`ICX_NSRC-1:0] lvl_act;
    logic [`ICX_NSRC-1:0] below_idx;

    always_comb begin
        lvl_act = arb_level ? (act & src_hi) : (act & ~src_hi);
        below_idx = ({{(`ICX_NSRC-1){1'b0}}, 1'b1} << arb_idx) - {{(`ICX_NSRC-1){1'b0}}, 1'b1};
    end

    sequence s_call_begun;
        long_call_start && !cpu_stall;
    endsequence

    sequence s_call_runs;
        (!cpu_stall)[*4];
    endsequence

    a_vector_position: assert property (@(posedge clk) disable iff (!reset_n)
        handler_enter |-> call_info.vector == `ICX_VEC_BASE + {8'h00, 3'h0, call_info.src} * 16'h0008)
        else $error("vector does not match source position");

    a_call_five: assert property (@(posedge clk) disable iff (!reset_n)
        s_call_begun ##1 s_call_runs |-> handler_enter)
        else $error("long call did not finish in five cycles");

    a_global_off: assert property (@(posedge clk) disable iff (!reset_n)
        !glb_en |=> !req_ff)
        else $error("request raised with global enable off");

    a_high_no_preempt: assert property (@(posedge clk) disable iff (!reset_n)
        srv_ff[1] && !return_from_interrupt |-> !long_call_start)
        else $error("high handler preempted");

    a_return_from_interrupt_boundary: assert property (@(posedge clk) disable iff (!reset_n)
        return_from_interrupt |-> !long_call_start)
        else $error("call issued on the return itself");

    a_stall_hold: assert property (@(posedge clk) disable iff (!reset_n)
        cpu_stall |-> !long_call_start && !handler_enter)
        else $error("servicing advanced during stall");

    a_level_mark: assert property (@(posedge clk) disable iff (!reset_n)
        handler_enter |=> srv_ff[$past(call_ff.level)])
        else $error("level not marked in service");

    a_high_first: assert property (@(posedge clk) disable iff (!reset_n)
        arb_valid && !arb_level |-> ((act & src_hi) == '0 || srv_ff[1] || nxt_srv[1]))
        else $error("low level granted over a high request");

    a_fixed_order: assert property (@(posedge clk) disable iff (!reset_n)
        arb_valid |-> (lvl_act & below_idx) == '0 && lvl_act[arb_idx])
        else $error("grant is not the lowest source number");

    a_detect_sample: assert property (@(posedge clk) disable iff (!reset_n)
        arb_valid |=> req_ff && req_info_ff.src == $past(arb_idx))
        else $error("request not sampled next cycle");

endmodule : icx_top

/* tb/icx_cpu.sv */
// CPU partner model: instruction ends, returns and stalls.
// Assumes the bench sets instruction length, return and stall requests.
`timescale 1ns/1ns
module icx_cpu (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bench controls
    input wire logic [3:0] ilen,
    input wire logic ret_req,
    input wire logic stall_req,
    input wire logic call_busy,
    // CPU outputs
    output logic cpu_instr_end,
    output logic return_from_interrupt,
    output logic cpu_stall
);
    logic [3:0] cnt_ff;
    // ****
    // Instruction sequencing
    // ****
    assign cpu_stall = stall_req;
    assign cpu_instr_end = !call_busy && !stall_req && cnt_ff >= ilen - 4'h1;
    assign return_from_interrupt = cpu_instr_end && ret_req;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cnt_ff <= 4'h0;
        else if (cpu_instr_end || call_busy)
            cnt_ff <= 4'h0;
        else if (!stall_req)
            cnt_ff <= cnt_ff + 4'h1;
    end
endmodule : icx_cpu

/* tb/testbench.sv */
// Self-checking bench of the interrupt controller against a reference model.
// Assumes icx_pkg, icx_top and icx_cpu are compiled first.
`timescale 1ns/1ns
module testbench
    import icx_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    icx_sfr_req_t sfr_req = '0;
    logic [20:0] src_flag = '0;
    logic t2l = 1'b0;
    logic t2h = 1'b0;
    logic [3:0] ilen = 4'h1;
    logic ret_req = 1'b0;
    logic stall_req = 1'b0;
    logic [7:0] sfr_rdata;
    logic cpu_instr_end, return_from_interrupt, cpu_stall, long_call_start, call_busy, handler_enter;
    icx_call_t call_info;
    icx_call_t exp_call;
    logic [1:0] level_in_service;
    logic [1:0] m_ins = 2'b00;
    logic p_lvl;
    bit chk_on;
    logic [7:0] mr [bit [7:0]];
    int bad_count = 0;
    int tests_run = 0;
    int calls = 0;
    int busy_n = 0;
    int cyc = 0;
    int w;
    int n;

    icx_top icx_top_i (.clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .src_flag(src_flag), .timer2_low_overflow_flag(t2l), .timer2_high_overflow_flag(t2h),
        .cpu_instr_end(cpu_instr_end), .return_from_interrupt(return_from_interrupt), .cpu_stall(cpu_stall),
        .long_call_start(long_call_start), .call_busy(call_busy), .handler_enter(handler_enter),
        .call_info(call_info), .level_in_service(level_in_service));
    icx_cpu icx_cpu_i (.clk(clk), .reset_n(reset_n), .ilen(ilen), .ret_req(ret_req), .stall_req(stall_req),
        .call_busy(call_busy), .cpu_instr_end(cpu_instr_end), .return_from_interrupt(return_from_interrupt),
        .cpu_stall(cpu_stall));

    always #2 clk = ~clk;

    // ****
    // Checks and reference model
    // ****
    task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_reg

    task automatic chk_call(input icx_call_t e, input icx_call_t g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error call_info expected %h seen %h", e, g);
        end
    endtask : chk_call

    function automatic int pick();
        logic [20:0] pend;
        logic [20:0] en;
        logic [20:0] hi;
        pend = src_flag;
        pend[5] = t2l | t2h;
        pend[17] = 1'b0;
        en = {mr[8'hE7][5:0], mr[8'hE6], mr[8'hA8][6:0]};
        hi = {mr[8'hF7][5:0], mr[8'hF6], mr[8'hB8][6:0]};
        for (int lv = 1; lv >= 0; lv--) begin
            for (int i = 0; i < 21; i++) begin
                if (mr[8'hA8][7] && pend[i] && en[i] && hi[i] == lv && (lv == 1 ? !m_ins[1] : m_ins == 2'b00)) begin
                    p_lvl = hi[i];
                    return i;
                end
            end
        end
        return -1;
    endfunction : pick

    function automatic void mset(input logic [7:0] a, input logic [7:0] d);
        if (mr.exists(a))
            mr[a] = (d | (a == 8'hB8 ? 8'h80 : 8'h00)) & (a == 8'hE7 || a == 8'hF7 ? 8'h3B : 8'hFF);
    endfunction : mset

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("Error timeout expected %0d seen %0d", 20000, cyc);
            finish_test();
        end
        if (reset_n) begin
            if (chk_on)
                chk_call(exp_call, call_info);
            chk_on = 1'b0;
            chk_reg("in_service", {6'h00, m_ins}, {6'h00, level_in_service});
            if (long_call_start) begin
                w = pick();
                chk_reg("call_gate", 8'h03, {6'h00, w >= 0, !(return_from_interrupt | cpu_stall)});
                exp_call = '{vector: 16'h0003 + 16'(w * 8), src: 5'(w), level: p_lvl};
                calls++;
                busy_n = 0;
                chk_on = 1'b1;
            end
            if (call_busy && !cpu_stall)
                busy_n++;
            if (handler_enter) begin
                chk_reg("call_len", 8'h04, 8'(busy_n));
                m_ins[exp_call.level] = 1'b1;
            end
            if (return_from_interrupt)
                m_ins[m_ins[1] ? 1 : 0] = 1'b0;
        end
    end

    // ****
    // Drivers
    // ****
    task automatic send(input icx_sfr_req_t r);
        sfr_req <= r;
        @(posedge clk);
        sfr_req <= '0;
        @(posedge clk);
    endtask : send

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        send('{addr: a, wdata: d, wr: 1'b1, default: '0});
        mset(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        send('{addr: a, rd: 1'b1, default: '0});
        chk_reg($sformatf("reg_%h", a), mr.exists(a) ? mr[a] : 8'h00, sfr_rdata);
    endtask : rd

    task automatic bop(input logic [7:0] a, input logic [2:0] i, input logic s);
        logic [7:0] v;
        send('{addr: a, bit_set: s, bit_clr: !s, bit_idx: i, default: '0});
        if (a == 8'hA8 || a == 8'hB8) begin
            v = mr[a];
            v[i] = s;
            mset(a, v);
        end
    endtask : bop

    task automatic wait_ev(input int k, output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!(k == 0 ? long_call_start : k == 1 ? handler_enter : return_from_interrupt) && c < 300);
        chk_reg("wait_event", 8'h00, {7'h00, c >= 300});
    endtask : wait_ev

    task automatic do_ret();
        int c;
        ret_req <= 1'b1;
        wait_ev(2, c);
        ret_req <= 1'b0;
    endtask : do_ret

    task automatic serve(input bit clr, input bit ret);
        int c;
        wait_ev(1, c);
        if (clr) begin
            src_flag[call_info.src] <= 1'b0;
            if (call_info.src == 5'h05) begin
                t2l <= 1'b0;
                t2h <= 1'b0;
            end
        end
        if (ret)
            do_ret();
    endtask : serve

    task automatic idle_chk();
        int c;
        c = calls;
        repeat (10) @(posedge clk);
        chk_reg("calls", 8'(c), 8'(calls));
    endtask : idle_chk

    // ****
    // Tests
    // ****
    initial begin
        void'($urandom(32'h4D7A));
        mr = '{8'hA8: 8'h00, 8'hB8: 8'h80, 8'hE6: 8'h00, 8'hE7: 8'h00, 8'hF6: 8'h00, 8'hF7: 8'h00};
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        foreach (mr[a])
            rd(a);
        rd(8'h55);
        wr(8'hA8, 8'($urandom));
        bop(8'hA8, 3'h7, 1'b1);
        bop(8'hA8, 3'h2, 1'b0);
        rd(8'hA8);
        bop(8'hE6, 3'h1, 1'b1);
        rd(8'hE6);
        $display("Test registers done");
        wr(8'hA8, 8'h7F);
        wr(8'hE6, 8'hFF);
        wr(8'hE7, 8'hFF);
        src_flag <= 21'h9;
        idle_chk();
        bop(8'hA8, 3'h7, 1'b1);
        serve(1'b1, 1'b1);
        serve(1'b1, 1'b1);
        $display("Test global enable done");
        src_flag[1] <= 1'b1;
        wait_ev(0, n);
        chk_reg("latency", 8'h02, 8'(n));
        serve(1'b1, 1'b1);
        for (int i = 0; i < 21; i++) begin
            if (i != 17) begin
                if (i == 5)
                    t2h <= 1'b1;
                else
                    src_flag[i] <= 1'b1;
                serve(1'b1, 1'b1);
            end
        end
        $display("Test vectors done");
        wr(8'hB8, 8'h0C);
        src_flag[0] <= 1'b1;
        serve(1'b1, 1'b0);
        src_flag[1] <= 1'b1;
        idle_chk();
        src_flag[2] <= 1'b1;
        serve(1'b1, 1'b0);
        src_flag[3] <= 1'b1;
        idle_chk();
        do_ret();
        serve(1'b1, 1'b1);
        idle_chk();
        do_ret();
        serve(1'b1, 1'b1);
        $display("Test preemption done");
        ilen <= 4'h8;
        src_flag[4] <= 1'b1;
        serve(1'b0, 1'b0);
        do_ret();
        wait_ev(0, n);
        chk_reg("reentry", 8'h08, 8'(n));
        serve(1'b1, 1'b1);
        ilen <= 4'h1;
        stall_req <= 1'b1;
        src_flag[6] <= 1'b1;
        idle_chk();
        stall_req <= 1'b0;
        wait_ev(0, n);
        stall_req <= 1'b1;
        repeat (3) @(posedge clk);
        stall_req <= 1'b0;
        serve(1'b1, 1'b1);
        $display("Test latency and stall done");
        repeat (12) begin
            wr(8'hB8, 8'($urandom));
            wr(8'hF6, 8'($urandom));
            wr(8'hF7, 8'($urandom));
            src_flag <= 21'($urandom);
            t2l <= 1'($urandom);
            @(posedge clk);
            for (int k = 0; k < 24 && pick() >= 0; k++)
                serve(1'b1, 1'b1);
        end
        $display("Test random priority done");
        finish_test();
    end
endmodule : testbench
